/* lct_pkg.sv */
// Purpose: constants and types for the loop compensation setup registers
// Assumes: command codes arrive already decoded from the management bus
// Notes:   one aligned storage word per command code except the start code, which has none
`default_nettype none
package lct_pkg;
  // command codes
  localparam logic [7:0]  CODE_COMP_SETUP   = 8'hbc;
  localparam logic [7:0]  CODE_COMP_START   = 8'hbd;
  localparam logic [7:0]  CODE_GAP_LIMIT    = 8'hbf;
  localparam logic [7:0]  CODE_VENDOR_MISC  = 8'hd0;
  // reset values
  localparam logic [15:0] RST_COMP_SETUP    = 16'h0000;
  localparam logic [15:0] RST_GAP_LIMIT     = 16'h0000;
  localparam logic [15:0] RST_VENDOR_MISC   = 16'h0000;
  // compensation setup fields
  localparam int          SETUP_PG_BIT      = 3;
  localparam int          SETUP_KEEP_BIT    = 2;
  localparam int          SETUP_MODE_LSB    = 0;
  localparam int          SETUP_MODE_W      = 2;
  // gap limit fields
  localparam int          GAP_HS_LSB        = 8;
  localparam int          GAP_LS_LSB        = 0;
  localparam int          GAP_W             = 8;
  // vendor misc field
  localparam int          MASK_LSB          = 11;
  localparam int          MASK_W            = 5;
  localparam int          MASK_STEP_NS      = 32;
  localparam int          MASK_STEP_SHIFT   = 5;
  localparam int          MASK_NS_W         = MASK_W + MASK_STEP_SHIFT;
  // timing
  localparam int          CLK_HZ            = 10_000_000;
  localparam int          REPEAT_SEC_S      = 1;
  localparam int          REPEAT_MIN_S      = 60;
  localparam int          SEC_CYCLES        = REPEAT_SEC_S * CLK_HZ;
  localparam int          MIN_CYCLES        = REPEAT_MIN_S * CLK_HZ;
  localparam int          TMR_W             = 30;

  typedef enum logic [1:0] {
    LCT_MODE_OFF  = 2'b00,
    LCT_MODE_ONCE = 2'b01,
    LCT_MODE_SEC  = 2'b10,
    LCT_MODE_MIN  = 2'b11
  } lct_mode_e;

  typedef enum logic [1:0] {
    LCT_XFER_READ = 2'b00,
    LCT_XFER_BYTE = 2'b01,
    LCT_XFER_WORD = 2'b10,
    LCT_XFER_SEND = 2'b11
  } lct_xfer_e;

  typedef enum logic [1:0] {
    LCT_ST_IDLE = 2'b01,
    LCT_ST_RUN  = 2'b10
  } lct_state_e;

  // one decoded management-bus transfer
  typedef struct packed {
    lct_xfer_e   kind;
    logic [7:0]  code;
    logic [15:0] data;
  } lct_cmd_s;

  // answer to one transfer
  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } lct_rsp_s;
endpackage
`default_nettype wire

/* lct_reg16.sv */
// Purpose: one 16-bit setup register with write strobe
// Assumes: reset already synchronised by the caller
// Notes:   narrower registers load zero into masked upper bits on write
`timescale 1ns/100ps
`default_nettype none
module lct_reg16 #(
  parameter logic [15:0] RESET = 16'h0000,
  parameter logic [15:0] MASK  = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        we,
  input  wire logic [15:0] wdata,
  output logic      [15:0] q
);
  logic [15:0] q_r;
  logic [15:0] q_nxt;

  // load on strobe, masked to implemented bits
  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt = wdata & MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

/* lct_comp_regs.sv */
// Purpose: compensation setup, start command, gap limits and sense masking
// Assumes: transfers arrive decoded, one per cmd_valid pulse
// Notes:   reset stands for input power being applied
// Summary of operation
// - setup bit 3 set: output ok waits for finished tuning run
// - setup bit 2 keeps results; run only on first ramp after power
// - setup bits 1:0 pick off, once, every second, every minute
// - send-byte 0xbd starts a run only when tuning enabled
// - gap word: two signed byte limits, high-to-low upper, low-to-high lower
// - vendor bits 15:11 give sense masking delay in 32 ns steps
`timescale 1ns/100ps
`default_nettype none
module lct_comp_regs
  import lct_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES,
  parameter int MIN_COUNT = MIN_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 cmd_valid,
  input  wire lct_cmd_s             cmd,
  output lct_rsp_s                  rsp,
  output logic                      rsp_valid,
  input  wire logic                 ramp_done,
  input  wire logic                 output_up,
  input  wire logic                 run_done,
  output logic                      run_start,
  output logic                      run_busy,
  output logic                      use_fixed_coeffs,
  output logic                      ok_wait_run,
  output logic signed [GAP_W-1:0]   gap_hs_to_ls,
  output logic signed [GAP_W-1:0]   gap_ls_to_hs,
  output logic        [MASK_NS_W-1:0] sense_mask_delay
);
  // reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // command decode
  logic        is_setup;
  logic        is_gap;
  logic        is_misc;
  logic        is_start;
  logic        we_setup;
  logic        we_gap;
  logic        we_misc;
  logic [15:0] setup_q;
  logic [15:0] gap_q;
  logic [15:0] misc_q;
  lct_mode_e   mode;
  logic        tuning_on;

  always_comb begin
    is_setup = 1'b0;
    is_gap   = 1'b0;
    is_misc  = 1'b0;
    is_start = 1'b0;
    if (cmd.code == CODE_COMP_SETUP) begin
      is_setup = 1'b1;
    end else if (cmd.code == CODE_COMP_START) begin
      is_start = 1'b1;
    end else if (cmd.code == CODE_GAP_LIMIT) begin
      is_gap = 1'b1;
    end else if (cmd.code == CODE_VENDOR_MISC) begin
      is_misc = 1'b1;
    end
  end

  // byte command for setup, word for the others
  assign we_setup = cmd_valid && is_setup && (cmd.kind == LCT_XFER_BYTE);
  assign we_gap   = cmd_valid && is_gap && (cmd.kind == LCT_XFER_WORD);
  assign we_misc  = cmd_valid && is_misc && (cmd.kind == LCT_XFER_WORD);

  lct_reg16 #(
    .RESET (RST_COMP_SETUP),
    .MASK  (16'h00ff)
  ) u_setup (
    .clk   (clk),
    .rst_b (rst_sync_r),
    .we    (we_setup),
    .wdata (cmd.data),
    .q     (setup_q)
  );

  lct_reg16 #(
    .RESET (RST_GAP_LIMIT),
    .MASK  (16'hffff)
  ) u_gap (
    .clk   (clk),
    .rst_b (rst_sync_r),
    .we    (we_gap),
    .wdata (cmd.data),
    .q     (gap_q)
  );

  lct_reg16 #(
    .RESET (RST_VENDOR_MISC),
    .MASK  (16'hffff)
  ) u_misc (
    .clk   (clk),
    .rst_b (rst_sync_r),
    .we    (we_misc),
    .wdata (cmd.data),
    .q     (misc_q)
  );

  assign mode      = lct_mode_e'(setup_q[SETUP_MODE_LSB +: SETUP_MODE_W]);
  assign tuning_on = (mode != LCT_MODE_OFF);

  // answer to each transfer, one cycle later
  lct_rsp_s rsp_r;
  lct_rsp_s rsp_nxt;
  logic     rsp_valid_r;
  always_comb begin
    rsp_nxt = rsp_r;
    if (cmd_valid) begin
      rsp_nxt.ack  = 1'b0;
      rsp_nxt.data = 16'h0000;
      if (is_start) begin
        rsp_nxt.ack = (cmd.kind == LCT_XFER_SEND);
      end else if (cmd.kind == LCT_XFER_READ) begin
        if (is_setup) begin
          rsp_nxt.ack  = 1'b1;
          rsp_nxt.data = setup_q;
        end else if (is_gap) begin
          rsp_nxt.ack  = 1'b1;
          rsp_nxt.data = gap_q;
        end else if (is_misc) begin
          rsp_nxt.ack  = 1'b1;
          rsp_nxt.data = misc_q;
        end
      end else begin
        rsp_nxt.ack = we_setup || we_gap || we_misc;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rsp_r       <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_r       <= rsp_nxt;
      rsp_valid_r <= cmd_valid;
    end
  end

  assign rsp       = rsp_r;
  assign rsp_valid = rsp_valid_r;

  // run sequencing state
  lct_state_e       state_r;
  lct_state_e       state_nxt;
  logic             kept_r;
  logic             kept_nxt;
  logic             done_r;
  logic             done_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic [TMR_W-1:0] tmr_end;
  logic             cmd_go;
  logic             ramp_go;
  logic             tmr_go;
  logic             periodic;

  // periodic runs rely on host keeping sharing groups out
  assign periodic = (mode == LCT_MODE_SEC) || (mode == LCT_MODE_MIN);
  assign tmr_end  = (mode == LCT_MODE_MIN) ? TMR_W'(MIN_COUNT - 1) : TMR_W'(SEC_COUNT - 1);
  // start command only when tuning enabled
  assign cmd_go   = cmd_valid && is_start && (cmd.kind == LCT_XFER_SEND) && tuning_on;
  // kept results suppress run on later ramps
  assign ramp_go  = ramp_done && tuning_on && !(setup_q[SETUP_KEEP_BIT] && kept_r);
  assign tmr_go   = periodic && output_up && (tmr_r == tmr_end);

  always_comb begin
    state_nxt = state_r;
    kept_nxt  = kept_r;
    done_nxt  = done_r;
    tmr_nxt   = tmr_r;
    run_start = 1'b0;
    // restart counting the interval while idle and output up
    if (!periodic || !output_up || state_r == LCT_ST_RUN || tmr_go) begin
      tmr_nxt = '0;
    end else begin
      tmr_nxt = tmr_r + TMR_W'(1);
    end
    // new ramp clears finished marker unless results are kept
    if (ramp_done && !(setup_q[SETUP_KEEP_BIT] && kept_r)) begin
      done_nxt = 1'b0;
    end
    // results dropped when retention switched off
    if (!setup_q[SETUP_KEEP_BIT]) begin
      kept_nxt = 1'b0;
    end
    case (state_r)
      LCT_ST_IDLE: begin
        if (cmd_go || ramp_go || tmr_go) begin
          run_start = 1'b1;
          state_nxt = LCT_ST_RUN;
        end
      end
      LCT_ST_RUN: begin
        if (run_done) begin
          state_nxt = LCT_ST_IDLE;
          done_nxt  = 1'b1;
          kept_nxt  = setup_q[SETUP_KEEP_BIT];
        end else if (!tuning_on) begin
          state_nxt = LCT_ST_IDLE;
        end
      end
      default: begin
        state_nxt = LCT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= LCT_ST_IDLE;
      kept_r  <= 1'b0;
      done_r  <= 1'b0;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      kept_r  <= kept_nxt;
      done_r  <= done_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  assign run_busy         = (state_r == LCT_ST_RUN);
  assign use_fixed_coeffs = !tuning_on;
  // output ok held back until run finished
  assign ok_wait_run      = setup_q[SETUP_PG_BIT] && tuning_on && !done_r;

  assign gap_hs_to_ls = gap_q[GAP_HS_LSB +: GAP_W];
  assign gap_ls_to_hs = gap_q[GAP_LS_LSB +: GAP_W];
  // masking delay in ns, field times 32
  assign sense_mask_delay = {misc_q[MASK_LSB +: MASK_W], {MASK_STEP_SHIFT{1'b0}}};
endmodule
`default_nettype wire

/* lct_comp_regs_props.sv */
// Purpose: port checks for the loop compensation setup block
// Assumes: one clock, rst_b active low
// Notes:   bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module lct_props
  import lct_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 cmd_valid,
  input wire lct_cmd_s             cmd,
  input wire lct_rsp_s             rsp,
  input wire logic                 run_done,
  input wire logic                 run_start,
  input wire logic                 run_busy,
  input wire logic                 use_fixed_coeffs,
  input wire logic                 ok_wait_run,
  input wire logic signed [7:0]    gap_hs_to_ls,
  input wire logic [MASK_NS_W-1:0] sense_mask_delay
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // decoded transfers
  wire logic wr_word = cmd_valid && cmd.kind == LCT_XFER_WORD;
  wire logic wr_set  = cmd_valid && cmd.kind == LCT_XFER_BYTE && cmd.code == CODE_COMP_SETUP;
  wire logic send_bd = cmd_valid && cmd.kind == LCT_XFER_SEND && cmd.code == CODE_COMP_START;
  chk_gap_write: assert property (wr_word && cmd.code == CODE_GAP_LIMIT |=> rsp.ack && gap_hs_to_ls == $past(cmd.data[15:8]))
    else $error("gap limit not taken");
  chk_mask_scale: assert property (wr_word && cmd.code == CODE_VENDOR_MISC |=> sense_mask_delay == {$past(cmd.data[15:11]), 5'h00})
    else $error("masking delay wrong");
  chk_mode_fixed: assert property (wr_set |=> use_fixed_coeffs == ($past(cmd.data[1:0]) == 2'h0))
    else $error("fixed coefficient select wrong");
  chk_off_nostart: assert property (use_fixed_coeffs |-> !run_start)
    else $error("run started while disabled");
  chk_send_start: assert property (send_bd && !use_fixed_coeffs && !run_busy |-> run_start)
    else $error("start command not acted on");
  chk_start_busy: assert property (run_start |=> run_busy)
    else $error("run not busy after start");
  chk_busy_nostart: assert property (run_busy |-> !run_start)
    else $error("start while busy");
  chk_off_okflag: assert property (use_fixed_coeffs |-> !ok_wait_run)
    else $error("output ok held while disabled");
  chk_done_clears: assert property (run_busy && run_done |=> !run_busy && !ok_wait_run)
    else $error("finished run not released");
  cover property (send_bd && run_start);
  cover property (run_busy && ok_wait_run);
  cover property (wr_set ##1 !use_fixed_coeffs);
endmodule
bind lct_comp_regs lct_props i_props (.clk, .rst_b, .cmd_valid, .cmd, .rsp, .run_done, .run_start, .run_busy,
  .use_fixed_coeffs, .ok_wait_run, .gap_hs_to_ls, .sense_mask_delay);
`default_nettype wire

/* lct_host_model.sv */
// Purpose: management host issuing decoded transfers
// Assumes: device answers one cycle after taking a transfer
// Notes:   released data lines show the inverse value
`timescale 1ns/100ps
`default_nettype none
module lct_host_model
  import lct_pkg::*;
#(
  parameter bit SHARE_GROUP = 1'b0
) (
  input  wire logic     clk,
  output var logic      cmd_valid,
  output var lct_cmd_s  cmd,
  input  wire lct_rsp_s rsp,
  input  wire logic     rsp_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one transfer, answer taken the next cycle
  task automatic xfer(input lct_xfer_e k, input logic [7:0] c, input logic [15:0] d,
                      output lct_rsp_s r, output logic v);
    if (SHARE_GROUP && k == LCT_XFER_BYTE && c == CODE_COMP_SETUP) d[1] = 1'b0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{k, c, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd.data = ~d;
    v = rsp_valid;
    r = rsp;
  endtask
endmodule
`default_nettype wire

/* lct_comp_regs_test.sv */
// Purpose: self-checking bench for the compensation setup block
// Assumes: short periodic counts in simulation
// Notes:   tuning engine stand-in finishes runs on demand
`timescale 1ns/100ps
`default_nettype none
module lct_comp_regs_test;
  import lct_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 ramp_done = 1'b0;
  logic                 output_up = 1'b0;
  logic                 run_done = 1'b0;
  logic                 auto_done = 1'b1;
  logic                 cmd_valid, rsp_valid, run_start, run_busy, use_fixed_coeffs, ok_wait_run, v;
  lct_cmd_s             cmd;
  lct_rsp_s             rsp, r;
  logic signed [7:0]    gap_hs_to_ls, gap_ls_to_hs;
  logic [MASK_NS_W-1:0] sense_mask_delay;
  int                   bad_count = 0;
  int                   num_checks = 0;
  int                   starts = 0;
  int                   s;
  always #50 clk = ~clk;
  // count starts, finish runs when allowed
  always @(posedge clk) if (run_start === 1'b1) starts <= starts + 1;
  always @(negedge clk) run_done <= auto_done && run_busy && !run_done;
  lct_comp_regs #(.SEC_COUNT(20), .MIN_COUNT(50)) i_dut (.clk, .rst_b, .cmd_valid, .cmd, .rsp, .rsp_valid,
    .ramp_done, .output_up, .run_done, .run_start, .run_busy, .use_fixed_coeffs, .ok_wait_run,
    .gap_hs_to_ls, .gap_ls_to_hs, .sense_mask_delay);
  lct_host_model i_host (.clk, .cmd_valid, .cmd, .rsp, .rsp_valid);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input lct_xfer_e k, input logic [7:0] c, input logic [15:0] d);
    i_host.xfer(k, c, d, r, v);
  endtask
  task automatic setup(input logic [15:0] d);
    wr(LCT_XFER_BYTE, CODE_COMP_SETUP, d);
  endtask
  task automatic kick;
    wr(LCT_XFER_SEND, CODE_COMP_START, 16'h0000);
  endtask
  task automatic ramp;
    @(negedge clk);
    ramp_done = 1'b1;
    @(negedge clk);
    ramp_done = 1'b0;
  endtask
  // limits, masking delay, refusals
  task automatic t_regs;
    wr(LCT_XFER_READ, CODE_GAP_LIMIT, 16'h0000);
    chk(r.data, RST_GAP_LIMIT);
    wr(LCT_XFER_WORD, CODE_GAP_LIMIT, 16'h3cf6);
    chk({gap_hs_to_ls, gap_ls_to_hs}, 16'h3cf6);
    wr(LCT_XFER_BYTE, CODE_GAP_LIMIT, 16'h0000);
    chk({v, r.ack, gap_hs_to_ls}, 16'h023c);
    wr(LCT_XFER_READ, CODE_GAP_LIMIT, 16'h0000);
    chk(r.data, 16'h3cf6);
    wr(LCT_XFER_READ, CODE_VENDOR_MISC, 16'h0000);
    chk(r.data, RST_VENDOR_MISC);
    wr(LCT_XFER_WORD, CODE_VENDOR_MISC, 16'hf8ff);
    chk(sense_mask_delay, 16'h03e0);
    wr(LCT_XFER_WORD, CODE_VENDOR_MISC, 16'h0800);
    chk(sense_mask_delay, 16'h0020);
    wr(LCT_XFER_READ, 8'h55, 16'h0000);
    chk({v, r.ack}, 16'h0002);
  endtask
  // every mode code
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      setup(16'hff00 | 16'(m));
      wr(LCT_XFER_READ, CODE_COMP_SETUP, 16'h0000);
      chk(r.data, 16'(m));
      chk(use_fixed_coeffs, 16'(m == 0));
    end
  endtask
  // start command, disabled and busy
  task automatic t_send;
    auto_done = 1'b0;
    setup(16'h0000);
    s = starts;
    kick;
    chk({r.ack, run_busy}, 16'h0002);
    wr(LCT_XFER_WORD, CODE_COMP_START, 16'h0000);
    chk(r.ack, 16'h0000);
    setup(16'h0001);
    kick;
    kick;
    chk(16'(starts - s), 16'h0001);
    chk(run_busy, 16'h0001);
    auto_done = 1'b1;
    repeat (3) @(negedge clk);
    chk(run_busy, 16'h0000);
  endtask
  // output ok timing and kept results
  task automatic t_pg;
    auto_done = 1'b0;
    setup(16'h000d);
    s = starts;
    ramp;
    chk({run_busy, ok_wait_run}, 16'h0003);
    auto_done = 1'b1;
    repeat (3) @(negedge clk);
    chk(ok_wait_run, 16'h0000);
    ramp;
    chk(16'(starts - s), 16'h0001);
    setup(16'h0001);
    ramp;
    chk(ok_wait_run, 16'h0000);
    repeat (3) @(negedge clk);
    ramp;
    chk(16'(starts - s), 16'h0003);
  endtask
  // repeated runs, second and minute
  task automatic t_periodic;
    setup(16'h0000);
    output_up = 1'b1;
    setup(16'h0002);
    s = starts;
    repeat (25) @(negedge clk);
    chk(16'(starts - s), 16'h0001);
    setup(16'h0000);
    setup(16'h0003);
    s = starts;
    repeat (40) @(negedge clk);
    chk(16'(starts - s), 16'h0000);
    repeat (20) @(negedge clk);
    chk(16'(starts - s), 16'h0001);
    output_up = 1'b0;
  endtask
  // power reapplied drops kept results
  task automatic t_power;
    setup(16'h0005);
    s = starts;
    ramp;
    repeat (3) @(negedge clk);
    ramp;
    rst_b = 1'b0;
    @(negedge clk);
    chk({run_busy, use_fixed_coeffs}, 16'h0001);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    setup(16'h0005);
    ramp;
    chk(16'(starts - s), 16'h0002);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk(use_fixed_coeffs, 16'h0001);
    t_regs;
    t_modes;
    t_send;
    t_pg;
    t_periodic;
    t_power;
    give_verdict;
  end
  // hang guard
  initial begin
    repeat (3000) @(negedge clk);
    bad_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
